// ### logic/spsc_pin_state.sv
// Per-pin drive and input-gate control across power modes
`timescale 1ns/1ps
`default_nettype none
`include "spsc_regs.svh"
// Functional notes
// R1: Reset-function pin is reset input always
// R2: Oscillator pins Hi-Z in stop/watch
// R3: Float 0: hold output, block input
// R4: Float 1: output Hi-Z, block input
// R5: Reset: Hi-Z, input enabled, value unused
// R6: Sleep behaves exactly like normal
// R7: Float 1 overrides direction on entry
// R8: Blocked input presents constant low
// R9: Mode registered; controls update next cycle
module spsc_pin_state #(
    parameter int NUM_PINS = `SPSC_NUM_PINS
) (
    input wire logic clk,
    input wire logic reset,
    input wire spsc_pkg::spsc_mode_t power_mode,
    input wire logic standby_pin_float,
    input wire logic [2*NUM_PINS-1:0] pin_function,
    input wire logic [NUM_PINS-1:0] port_out,
    input wire logic [NUM_PINS-1:0] port_dir,
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe,
    output logic [NUM_PINS-1:0] pad_ie,
    output logic [NUM_PINS-1:0] port_in,
    output logic [NUM_PINS-1:0] osc_in_en,
    output logic [NUM_PINS-1:0] reset_in_en,
    output logic pin_reset_req
);
    import spsc_pkg::*;

    // Two code bits a pin; beyond 32 pins the function bus grows unwieldy
    if (NUM_PINS < 1 || NUM_PINS > 32) begin : g_bad_pins
        $error("NUM_PINS out of range");
    end

    spsc_mode_t mode_q;
    logic float_q;
    logic [NUM_PINS-1:0] sync_in;
    logic [NUM_PINS-1:0] hold_out_q;
    logic [NUM_PINS-1:0] hold_oe_q;
    logic [NUM_PINS-1:0] pad_out_d;
    logic [NUM_PINS-1:0] pad_oe_d;
    logic [NUM_PINS-1:0] pad_ie_d;
    logic [NUM_PINS-1:0] port_in_d;
    logic [NUM_PINS-1:0] osc_d;
    logic [NUM_PINS-1:0] rst_d;
    logic [NUM_PINS-1:0] osc_pins;
    logic [NUM_PINS-1:0] rst_pins;
    logic [NUM_PINS-1:0] port_pins;

    // Function code of one pin
    function automatic spsc_fn_t fn_of(input logic [2*NUM_PINS-1:0] f, input int i);
        fn_of = spsc_fn_t'(f[2*i +: 2]);
    endfunction : fn_of

    // True in the two deep standby modes
    function automatic logic is_standby(input spsc_mode_t m);
        is_standby = (m == SPSC_MODE_STOP) || (m == SPSC_MODE_WATCH);
    endfunction : is_standby

    // Pin kinds decoded once for the checks below; code 3 counts as a port
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            osc_pins[i] = (fn_of(pin_function, i) == SPSC_FN_OSC);
            rst_pins[i] = (fn_of(pin_function, i) == SPSC_FN_RESET);
            port_pins[i] = !osc_pins[i] && !rst_pins[i];
        end
    end

    spsc_sync #(.WIDTH(NUM_PINS)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in(pad_in),
        .sync_out(sync_in)
    );

    // Mode and float setting registered before use
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_q <= SPSC_MODE_RESET;
            float_q <= `SPSC_FLOAT_RESET;
        end else begin
            mode_q <= power_mode; // R9
            float_q <= standby_pin_float;
        end
    end

    // Snapshot of drive state, frozen while in standby so it can be held
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_out_q <= '0;
            hold_oe_q <= '0;
        end else if (!is_standby(mode_q)) begin
            hold_out_q <= port_out;
            hold_oe_q <= port_dir;
        end
    end

    // Per-pin decision
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pad_out_d[i] = 1'b0;
            pad_oe_d[i] = 1'b0;
            pad_ie_d[i] = 1'b0;
            port_in_d[i] = `SPSC_BLOCKED_LEVEL; // R8
            osc_d[i] = 1'b0;
            rst_d[i] = 1'b0;
            if (fn_of(pin_function, i) == SPSC_FN_RESET) begin
                pad_ie_d[i] = 1'b1; // R1
                rst_d[i] = 1'b1; // R1
            end else if (fn_of(pin_function, i) == SPSC_FN_OSC) begin
                // Oscillator keeps running through sleep only
                osc_d[i] = !is_standby(mode_q) && mode_q != SPSC_MODE_RESET; // R2 R6
            end else begin
                unique case (mode_q)
                    SPSC_MODE_NORMAL, SPSC_MODE_SLEEP: begin
                        pad_out_d[i] = port_out[i]; // R6
                        pad_oe_d[i] = port_dir[i];
                        pad_ie_d[i] = 1'b1;
                        port_in_d[i] = sync_in[i];
                    end
                    SPSC_MODE_STOP, SPSC_MODE_WATCH: begin
                        if (!float_q) begin
                            pad_out_d[i] = hold_out_q[i]; // R3
                            pad_oe_d[i] = hold_oe_q[i]; // R3
                        end else begin
                            // Float 1 forces oe low whatever the direction says
                            pad_oe_d[i] = 1'b0; // R4 R7
                        end
                    end
                    SPSC_MODE_RESET: begin
                        pad_ie_d[i] = 1'b1; // R5
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Pad controls from flip-flops, one cycle after mode register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_ie <= '1;
            port_in <= '0;
            osc_in_en <= '0;
            reset_in_en <= '0;
        end else begin
            pad_out <= pad_out_d;
            pad_oe <= pad_oe_d;
            pad_ie <= pad_ie_d;
            port_in <= port_in_d;
            osc_in_en <= osc_d;
            reset_in_en <= rst_d;
        end
    end

    // Reset request from any reset-function pin held low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_reset_req <= 1'b0;
        end else begin
            pin_reset_req <= |(reset_in_en & ~sync_in); // R1
        end
    end

    a_standby_block: assert property (@(posedge clk) disable iff (reset) // R8
        is_standby(mode_q) |=> (port_in == '0))
        else $error("input not blocked in standby");

    a_float_hiz: assert property (@(posedge clk) disable iff (reset) // R4
        (is_standby(mode_q) && float_q) |=> (pad_oe == '0))
        else $error("pad driven with float set");

    a_hold_state: assert property (@(posedge clk) disable iff (reset) // R3
        (is_standby(mode_q) && !float_q && $stable(mode_q)) |=> $stable(pad_oe))
        else $error("drive not held in standby");

    a_standby_ie_off: assert property (@(posedge clk) disable iff (reset) // R3
        is_standby(mode_q) |=> ((pad_ie & $past(port_pins)) == '0))
        else $error("port input buffer on in standby");

    a_reset_mode: assert property (@(posedge clk) disable iff (reset) // R5
        (mode_q == SPSC_MODE_RESET && pin_function == '0)
        |=> (pad_oe == '0 && pad_ie == '1 && port_in == '0))
        else $error("reset mode pad state wrong");

    a_sleep_same: assert property (@(posedge clk) disable iff (reset) // R6
        (mode_q == SPSC_MODE_SLEEP && pin_function == '0) |=> (pad_oe == $past(port_dir)))
        else $error("sleep differs from normal");

    a_mode_latency: assert property (@(posedge clk) disable iff (reset) // R9
        (power_mode == SPSC_MODE_NORMAL && pin_function == '0)
        ##1 (power_mode == SPSC_MODE_STOP && standby_pin_float)
        ##1 (pin_function == '0) |=> (pad_oe == '0))
        else $error("controls late after mode change");

    a_osc_standby: assert property (@(posedge clk) disable iff (reset) // R2
        is_standby(mode_q) |=> (osc_in_en == '0))
        else $error("oscillator enabled in standby");

    a_osc_pad_off: assert property (@(posedge clk) disable iff (reset) // R2
        (|osc_pins) |=> (((pad_oe | pad_ie) & $past(osc_pins)) == '0))
        else $error("oscillator pad buffer enabled");

    a_reset_pin: assert property (@(posedge clk) disable iff (reset) // R1
        (|rst_pins) |=> ((reset_in_en & pad_ie & $past(rst_pins)) == $past(rst_pins)))
        else $error("reset pin lost its function");

    a_reset_req_idle: assert property (@(posedge clk) disable iff (reset) // R1
        (reset_in_en == '0) |=> !pin_reset_req)
        else $error("reset request without a reset pin");
endmodule : spsc_pin_state
`default_nettype wire

// ### logic/spsc_pkg.sv
// Types for the standby pin-state control block
`default_nettype none
package spsc_pkg;
    typedef enum logic [2:0] {
        SPSC_MODE_NORMAL,
        SPSC_MODE_SLEEP,
        SPSC_MODE_STOP,
        SPSC_MODE_WATCH,
        SPSC_MODE_RESET
    } spsc_mode_t;
    typedef enum logic [1:0] {
        SPSC_FN_PORT,
        SPSC_FN_OSC,
        SPSC_FN_RESET
    } spsc_fn_t;
endpackage : spsc_pkg
`default_nettype wire

// ### logic/spsc_regs.svh
// Constants for the standby pin-state control block
`ifndef SPSC_REGS_SVH
`define SPSC_REGS_SVH
`define SPSC_NUM_PINS 8
`define SPSC_FLOAT_RESET 1'b0
`define SPSC_BLOCKED_LEVEL 1'b0
`endif

// ### logic/spsc_sync.sv
// Two-stage synchroniser for the pad inputs
`timescale 1ns/1ps
`default_nettype none
module spsc_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // A zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    // First stage is read only by the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : spsc_sync
`default_nettype wire

// ### verif/spsc_board.sv
// Board model: the level each pad carries
`timescale 1ns/1ps
`default_nettype none
module spsc_board (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] board_drive,
    output logic [7:0] pad_in
);
    // A pin the chip drives shows the chip's value; a released pin shows the board's own level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_drive);
endmodule : spsc_board
`default_nettype wire

// ### verif/standby_pin_state_control_test.sv
// Self-checking bench for the standby pin-state control
`timescale 1ns/1ps
`default_nettype none
module standby_pin_state_control_test;
    import spsc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    spsc_mode_t power_mode = SPSC_MODE_RESET;
    logic standby_pin_float = 1'b0;
    // Pin 0 oscillator, pin 1 reset, the rest port pins
    logic [15:0] pin_function = 16'h0009;
    logic [7:0] port_out = 8'h00;
    logic [7:0] port_dir = 8'h00;
    logic [7:0] board_drive = 8'h00;
    logic [7:0] pad_in, pad_out, pad_oe, pad_ie, port_in, osc_in_en, reset_in_en;
    logic pin_reset_req;
    int mismatches = 0;
    int checks_done = 0;

    // Half period of 25 ns gives 20 MHz
    always #25 clk = ~clk;

    spsc_pin_state #(.NUM_PINS(8)) uut (.clk(clk), .reset(reset), .power_mode(power_mode),
        .standby_pin_float(standby_pin_float), .pin_function(pin_function),
        .port_out(port_out), .port_dir(port_dir), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_ie(pad_ie), .port_in(port_in), .osc_in_en(osc_in_en),
        .reset_in_en(reset_in_en), .pin_reset_req(pin_reset_req));
    spsc_board board (.pad_out(pad_out), .pad_oe(pad_oe), .board_drive(board_drive),
        .pad_in(pad_in));

    task automatic finish_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Masked compare; bits outside the mask are not defined for that pin kind
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
        checks_done++;
        if ((got & mask) !== (exp & mask)) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got & mask, exp & mask);
        end
    endtask : chk

    // Mode and float change at an edge, then settle n cycles
    task automatic go(input spsc_mode_t m, input logic f, input int n);
        @(posedge clk);
        power_mode <= m;
        standby_pin_float <= f;
        repeat (n) @(posedge clk);
        #1;
    endtask : go

    task automatic check_reset_state;
        chk(pad_oe, 8'h00, 8'hFF);
        chk(pad_ie, 8'hFF, 8'hFC);
        chk(port_in, 8'h00, 8'hFC);
    endtask : check_reset_state

    // Normal and sleep must look alike; the osc pin's direction bit is set but must not drive
    task automatic run_active(input spsc_mode_t m);
        @(posedge clk);
        port_out <= 8'hA5;
        port_dir <= 8'hF1;
        board_drive <= 8'h3C;
        go(m, 1'b0, 6);
        chk(pad_oe, 8'hF0, 8'hFD);
        chk(pad_out, 8'hA5, 8'hF0);
        chk(pad_ie, 8'hFE, 8'hFF);
        chk(port_in, 8'hAC, 8'hFC);
        chk(osc_in_en, 8'h01, 8'h01);
        chk(reset_in_en, 8'h02, 8'h02);
        chk({7'h00, pin_reset_req}, 8'h01, 8'h01);
    endtask : run_active

    // Standby entry, then port settings change and must be ignored
    task automatic run_standby(input spsc_mode_t m, input logic f);
        run_active(SPSC_MODE_NORMAL);
        go(m, f, 4);
        @(posedge clk);
        port_out <= 8'h5A;
        port_dir <= 8'h0F;
        board_drive <= 8'hFF;
        repeat (6) @(posedge clk);
        #1;
        chk(pad_oe, f ? 8'h00 : 8'hF0, 8'hFD);
        chk(pad_out, 8'hA5, f ? 8'h00 : 8'hF0);
        chk(pad_ie, 8'h02, 8'hFF);
        chk(port_in, 8'h00, 8'hFC);
        chk(osc_in_en, 8'h00, 8'h01);
        chk(reset_in_en, 8'h02, 8'h02);
        chk({7'h00, pin_reset_req}, 8'h00, 8'h01);
    endtask : run_standby

    // All pins as ports, then the spare code 3 on pin 7, which must act as a port
    task automatic run_all_port;
        @(posedge clk);
        pin_function <= 16'h0000;
        port_out <= 8'h96;
        port_dir <= 8'hC3;
        board_drive <= 8'h0F;
        go(SPSC_MODE_SLEEP, 1'b0, 6);
        chk(pad_oe, 8'hC3, 8'hFF);
        chk(pad_out, 8'h96, 8'hFF);
        chk(port_in, 8'h8E, 8'hFF);
        chk({7'h00, pin_reset_req}, 8'h00, 8'h01);
        go(SPSC_MODE_NORMAL, 1'b0, 2);
        go(SPSC_MODE_STOP, 1'b1, 2);
        chk(pad_oe, 8'h00, 8'hFF);
        go(SPSC_MODE_RESET, 1'b0, 4);
        chk(pad_oe, 8'h00, 8'hFF);
        chk(pad_ie, 8'hFF, 8'hFF);
        chk(port_in, 8'h00, 8'hFF);
        @(posedge clk);
        pin_function <= 16'hC000;
        go(SPSC_MODE_NORMAL, 1'b0, 6);
        chk(pad_oe, 8'hC3, 8'hFF);
        chk(port_in, 8'h8E, 8'hFF);
    endtask : run_all_port

    // Reset mode with the usual pin kinds; the reset pin keeps its job
    task automatic run_reset_mode;
        @(posedge clk);
        pin_function <= 16'h0009;
        go(SPSC_MODE_RESET, 1'b0, 4);
        check_reset_state();
        chk(reset_in_en, 8'h02, 8'h02);
        chk(osc_in_en, 8'h00, 8'h01);
    endtask : run_reset_mode

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1;
        check_reset_state();
        @(posedge clk);
        reset <= 1'b0;
        run_active(SPSC_MODE_NORMAL);
        run_active(SPSC_MODE_SLEEP);
        for (int i = 0; i < 4; i++) begin
            run_standby(i[1] ? SPSC_MODE_WATCH : SPSC_MODE_STOP, i[0]);
        end
        run_all_port();
        run_reset_mode();
        finish_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        finish_test();
    end
endmodule : standby_pin_state_control_test
`default_nettype wire
